// ==== design/adcsr_device.sv ====
// Converter end of the serial link: result register, serial shifter, configuration.
// Assumes the analog core reports each finished result with a one-cycle conv_done.
//
// Functional notes
// - Config bit 0 defaults one; zero resets.
// - Result captured at done, presented at select fall.
// - Host avoids shifting near end of sampling.
// - Sampling ends at start fall or third clock.
// - Host keeps select fall off conversion end.
// - Early select reads old, late reads new.
// - Result is sixteen-bit straight binary.
// - Host normally gives sixteen clocks per read.
// - Result leaves most significant bit first.
// - Tag then zeros, low until select rises.
// - Data output drives only while select low.
// - Short frames emit that many leading bits.
// - First frame after reset outputs all ones.
// - Host reads during conversion, not sampling.
// - Tag bit names the source input.
// - Tagged frames need more than sixteen clocks.
// - Config bit one enables tag, seventeenth clock.
// - Tagged frames seventeen or more, else sixteen.
// - Any reset restores all-ones configuration.
module adcsr_device
	import adcsr_pkg::*;
#(
	parameter bit DUAL_INPUT = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	adcsr_link_if.device link,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic conv_channel,
	output logic end_of_sampling,
	output logic [CFG_W-1:0] cfg_readback
);
	logic [2:0] pin_raw;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_filt;
	logic [2:0] pin_prev;
	logic sdi_s1;
	logic sdi_s2;
	logic sdi_s3;
	logic sdi_filt;
	logic soft_rst;
	logic core_rst;
	logic fs_low;
	logic fs_fall;
	logic fs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic convert_start_n_fall;
	logic [CFG_W-1:0] configuration_register;
	logic tag_en;
	logic [RES_W-1:0] odr_in;
	logic odr_chan;
	logic [SHIFT_W-1:0] output_data_register;
	logic first_frame;
	logic [FRAME_W-1:0] rx_sr;
	logic [5:0] rx_cnt;
	logic [$clog2(CONVERSION_CLOCK_DIV)-1:0] conversion_clock_cnt;
	logic conversion_clock;
	logic eos_armed;
	logic [1:0] eos_cnt;

	assign pin_raw = {link.sclk, link.frame_sync_n, link.convert_start_n};

	// A pin level is taken only once the last two stages agree, so a single
	// metastable sample never produces a false edge.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			pin_s3 <= PIN_IDLE;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			sdi_s3 <= 1'b0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			sdi_s1 <= link.sdi;
			sdi_s2 <= sdi_s1;
			sdi_s3 <= sdi_s2;
		end
	end

	for (genvar i = 0; i < 3; i++) begin : g_pin_filt
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				pin_filt[i] <= PIN_IDLE[i];
				pin_prev[i] <= PIN_IDLE[i];
			end else begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_filt[i] <= pin_s3[i];
				end
				pin_prev[i] <= pin_filt[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sdi_filt <= 1'b0;
		end else if (sdi_s2 == sdi_s3) begin
			sdi_filt <= sdi_s3;
		end
	end

	assign fs_low = ~pin_filt[PIN_FS];
	assign fs_fall = pin_prev[PIN_FS] & ~pin_filt[PIN_FS];
	assign fs_rise = ~pin_prev[PIN_FS] & pin_filt[PIN_FS];
	assign sclk_rise = ~pin_prev[PIN_SCLK] & pin_filt[PIN_SCLK];
	assign sclk_fall = pin_prev[PIN_SCLK] & ~pin_filt[PIN_SCLK];
	assign convert_start_n_fall = pin_prev[PIN_CONVERT_START_N] & ~pin_filt[PIN_CONVERT_START_N];

	// Power-on and software reset are merged for the core state; the pin synchronizers and filters take power-on reset only.
	assign core_rst = ~rst_b | soft_rst;

	// Command frames: four opcode bits then twelve configuration bits.
	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			rx_sr <= '0;
			rx_cnt <= 6'h00;
		end else if (fs_fall) begin
			rx_cnt <= 6'h00;
		end else if (sclk_rise && fs_low) begin
			rx_sr <= {rx_sr[FRAME_W-2:0], sdi_filt};
			if (rx_cnt != 6'h3F) begin
				rx_cnt <= rx_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			configuration_register <= CFG_RESET;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= 1'b0;
			if (fs_rise && rx_cnt >= 6'(FRAME_W) && rx_sr[FRAME_W-1:CFG_W] == CMD_WRITE_CFG) begin
				// A zero in the lowest bit requests a full reset of the device; the
				// register keeps its value until that reset restores the defaults.
				if (rx_sr[CFG_RST_BIT]) begin
					configuration_register <= rx_sr[CFG_W-1:0];
				end
				soft_rst <= ~rx_sr[CFG_RST_BIT];
			end
		end
	end

	assign tag_en = DUAL_INPUT & configuration_register[CFG_TAG_BIT];

	always_comb begin
		cfg_readback = configuration_register;
		// The single-input variant ignores the tag bit and reads it as zero.
		cfg_readback[CFG_TAG_BIT] = tag_en;
	end

	// The register input follows every finished result; the output side loads one
	// only on a select fall, so a frame in progress never sees a new value.
	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			odr_in <= '0;
			odr_chan <= 1'b0;
		end else if (conv_done) begin
			odr_in <= conv_result;
			odr_chan <= conv_channel;
		end
	end

	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			first_frame <= 1'b1;
		end else if (fs_rise) begin
			first_frame <= 1'b0;
		end
	end

	// A select fall in the same cycle as conv_done still loads the old value,
	// which is why the host must keep the two apart.
	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			output_data_register <= '0;
		end else if (fs_fall) begin
			if (first_frame) begin
				output_data_register <= '1;
			end else begin
				output_data_register <= {odr_in, tag_en & odr_chan};
			end
		end else if (sclk_fall && fs_low) begin
			// Zeros fill behind the tag, ones during the first frame after reset.
			output_data_register <= {output_data_register[SHIFT_W-2:0], first_frame};
		end
	end

	// Outside the first frame after reset, with tagging off the trailing position
	// was loaded with zero, so the seventeenth clock already shows the zero fill.
	assign link.sdo = output_data_register[SHIFT_W-1];
	assign link.sdo_oe = fs_low;

	// Internal conversion clock, one tick per period.
	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			conversion_clock_cnt <= '0;
		end else if (conversion_clock_cnt == ($clog2(CONVERSION_CLOCK_DIV))'(CONVERSION_CLOCK_DIV - 1)) begin
			conversion_clock_cnt <= '0;
		end else begin
			conversion_clock_cnt <= conversion_clock_cnt + 1'b1;
		end
	end

	assign conversion_clock = conversion_clock_cnt == ($clog2(CONVERSION_CLOCK_DIV))'(CONVERSION_CLOCK_DIV - 1);

	always_ff @(posedge core_clk) begin
		if (core_rst) begin
			eos_armed <= 1'b0;
			eos_cnt <= 2'h0;
			end_of_sampling <= 1'b0;
		end else begin
			end_of_sampling <= 1'b0;
			if (configuration_register[CFG_MANUAL_TRIG_BIT]) begin
				eos_armed <= 1'b0;
				end_of_sampling <= convert_start_n_fall;
			end else if (conv_done) begin
				eos_armed <= 1'b1;
				eos_cnt <= 2'h0;
			end else if (eos_armed && conversion_clock) begin
				if (eos_cnt == EOS_CCLKS - 2'h1) begin
					eos_armed <= 1'b0;
					end_of_sampling <= 1'b1;
				end
				eos_cnt <= eos_cnt + 2'h1;
			end
		end
	end
endmodule

// ==== design/adcsr_pkg.sv ====
// Shared constants for the serial result readout link of a 16-bit converter.
// Assumes both ends run on one 100 MHz core clock and import this package whole.
package adcsr_pkg;
	localparam int RES_W = 16;
	localparam int CMD_W = 4;
	localparam int CFG_W = 12;
	localparam int SHIFT_W = RES_W + 1;
	localparam int FRAME_W = CMD_W + CFG_W;
	localparam logic [CFG_W-1:0] CFG_RESET = 12'hFFF;
	localparam int CFG_RST_BIT = 0;
	localparam int CFG_TAG_BIT = 1;
	localparam int CFG_MANUAL_TRIG_BIT = 9;
	localparam logic [CMD_W-1:0] CMD_WRITE_CFG = 4'hE;
	localparam logic [2:0] PIN_IDLE = 3'h3;
	localparam int PIN_SCLK = 2;
	localparam int PIN_FS = 1;
	localparam int PIN_CONVERT_START_N = 0;
	localparam int CONVERSION_CLOCK_DIV = 5;
	localparam logic [1:0] EOS_CCLKS = 2'h3;
	localparam int CLK_NS = 10;
	localparam int QUIET_NS = 20;
	localparam int QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_HALF = 8;
	localparam int PLAIN_CLKS = 16;
	localparam int MIN_TAG_CLKS = 17;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RXDATA = 4'h8;
	localparam logic [3:0] REG_CONV = 4'hC;
	localparam int CMD_CNT_LSB = 16;
	localparam int CMD_CNT_W = 6;
	localparam int CMD_TAG_BIT = 24;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CONV_BIT = 1;
endpackage

// ==== design/adcsr_link_if.sv ====
// Serial link between the converter end and the host end.
// Assumes the bench joins both modports; sdo_oe marks when the data line is driven.
interface adcsr_link_if;
	logic sclk;
	logic frame_sync_n;
	logic convert_start_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;

	modport device(
		input sclk,
		input frame_sync_n,
		input convert_start_n,
		input sdi,
		output sdo,
		output sdo_oe
	);
	modport host(
		output sclk,
		output frame_sync_n,
		output convert_start_n,
		output sdi,
		input sdo,
		input sdo_oe
	);
endinterface

// ==== design/adcsr_host.sv ====
// Host end of the serial link, steered by software over an Avalon-MM slave.
// Assumes the converter end samples the link pins with its own clock.
module adcsr_host
	import adcsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	adcsr_link_if.host link
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL} adcsr_state_t;

	adcsr_state_t state;
	logic ack;
	logic busy;
	logic stall;
	logic [3:0] div;
	logic div_done;
	logic [CMD_CNT_W-1:0] nclk;
	logic [CMD_CNT_W-1:0] next_nclk;
	logic [CMD_CNT_W-1:0] clk_cnt;
	logic [FRAME_W-1:0] tx_sr;
	logic [31:0] rx_sr;
	logic [1:0] quiet;
	logic start;

	assign busy = state != ST_IDLE;
	// Requests that would disturb a frame wait; this also keeps a start pulse
	// out of the middle of a frame.
	assign stall = busy & write & (address == REG_CMD | address == REG_CONV);
	assign waitrequest = (read | write) & ~ack;
	assign start = write & ack & address == REG_CMD;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack <= (read | write) & ~ack & ~stall;
			if (read & ~ack) begin
				unique case (address)
					REG_STATUS: readdata <= {30'h0, link.convert_start_n, busy};
					REG_RXDATA: readdata <= rx_sr;
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Tagged reads need at least seventeen clocks; shorter requests are stretched.
	always_comb begin
		next_nclk = writedata[CMD_CNT_LSB +: CMD_CNT_W];
		if (writedata[CMD_TAG_BIT] && next_nclk < CMD_CNT_W'(MIN_TAG_CLKS)) begin
			next_nclk = CMD_CNT_W'(MIN_TAG_CLKS);
		end else if (next_nclk == '0) begin
			next_nclk = CMD_CNT_W'(PLAIN_CLKS);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			link.convert_start_n <= 1'b1;
			quiet <= 2'h0;
		end else if (write && ack && address == REG_CONV) begin
			link.convert_start_n <= writedata[0];
			if (link.convert_start_n && !writedata[0]) begin
				quiet <= 2'(QUIET_CYC);
			end
		end else if (quiet != 2'h0) begin
			quiet <= quiet - 2'h1;
		end
	end

	assign div_done = div == 4'(SCLK_HALF - 1) && quiet == 2'h0;

	always_ff @(posedge core_clk) begin
		if (!rst_b || state == ST_IDLE || div_done) begin
			div <= 4'h0;
		end else if (div != 4'(SCLK_HALF - 1)) begin
			div <= div + 4'h1;
		end
	end

	// Data are sampled on the rising edge, half a period after the device has
	// moved its output on the falling edge.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			link.frame_sync_n <= 1'b1;
			link.sclk <= 1'b0;
			link.sdi <= 1'b0;
			tx_sr <= '0;
			rx_sr <= 32'h0000_0000;
			nclk <= '0;
			clk_cnt <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						tx_sr <= writedata[FRAME_W-1:0];
						link.sdi <= writedata[FRAME_W-1];
						nclk <= next_nclk;
						clk_cnt <= '0;
						rx_sr <= 32'h0000_0000;
						link.frame_sync_n <= 1'b0;
						state <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (div_done) begin
						link.sclk <= 1'b1;
						rx_sr <= {rx_sr[30:0], link.sdo};
						state <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (div_done) begin
						link.sclk <= 1'b0;
						tx_sr <= {tx_sr[FRAME_W-2:0], 1'b0};
						link.sdi <= tx_sr[FRAME_W-2];
						clk_cnt <= clk_cnt + 1'b1;
						state <= (clk_cnt == nclk - 1'b1) ? ST_TAIL : ST_LOW;
					end
				end
				ST_TAIL: begin
					if (div_done) begin
						link.frame_sync_n <= 1'b1;
						link.sdi <= 1'b0;
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ==== tb/adcsr_link_props.sv ====
// Concurrent checks on the serial link and on the converter end's outputs.
// Assumes one core clock domain; the bench instantiates it beside the link.
module adcsr_link_props
	import adcsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic frame_sync_n,
	input wire logic convert_start_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic conv_done,
	input wire logic end_of_sampling,
	input wire logic [CFG_W-1:0] cfg_readback
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_oe_on_select: assert property ($fell(frame_sync_n) |-> ##[1:8] sdo_oe)
		else $error("data output not driven after select fall");
	a_oe_off_select: assert property ($rose(frame_sync_n) |-> ##[1:8] !sdo_oe)
		else $error("data output still driven after select rise");
	a_oe_quiet_idle: assert property (frame_sync_n [*8] |-> !sdo_oe)
		else $error("data output driven while select high");
	// Bits move only on the falling serial clock, so the rising half must hold still.
	a_sdo_bit_hold: assert property ($rose(sclk) && sdo_oe |=> $stable(sdo) [*6])
		else $error("data bit changed while serial clock high");
	a_cfg_after_reset: assert property (disable iff (1'b0) !rst_b |=> cfg_readback == CFG_RESET)
		else $error("configuration not all ones after reset");
	a_cfg_run_bit: assert property (cfg_readback[CFG_RST_BIT])
		else $error("configuration run bit left low");
	a_eos_manual_fall: assert property (cfg_readback[CFG_MANUAL_TRIG_BIT] && $fell(convert_start_n)
		|-> ##[1:8] end_of_sampling)
		else $error("no end of sampling after convert start fall");
	a_eos_auto_done: assert property (!cfg_readback[CFG_MANUAL_TRIG_BIT] && conv_done
		|-> ##[8:20] end_of_sampling)
		else $error("no end of sampling after conversion done");
	a_eos_one_pulse: assert property (end_of_sampling |=> !end_of_sampling)
		else $error("end of sampling longer than one cycle");
endmodule

// ==== tb/adc_serial_result_readout_tb.sv ====
// Self-checking bench: software drives the host end over Avalon-MM into the converter end.
// Assumes the package and link interface compile first; one 100 MHz core clock.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module adc_serial_result_readout_tb
	import adcsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
	logic conv_done = 1'b0, conv_channel = 1'b0, ch;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, rd_q;
	logic [15:0] conv_result = 16'h0, r;
	logic waitrequest, end_of_sampling;
	logic [CFG_W-1:0] cfg_readback;
	logic [15:0] corner [3] = '{16'hFFFF, 16'h8000, 16'h0000};
	int n_fail = 0, samples_checked = 0, n, eos_n = 0, k0;

	adcsr_link_if u_adcsr_link_if();
	adcsr_device u_adcsr_device(.core_clk(core_clk), .rst_b(rst_b), .link(u_adcsr_link_if),
		.conv_done(conv_done), .conv_result(conv_result), .conv_channel(conv_channel),
		.end_of_sampling(end_of_sampling), .cfg_readback(cfg_readback));
	adcsr_host u_adcsr_host(.core_clk(core_clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .link(u_adcsr_link_if));
	adcsr_link_props u_adcsr_link_props(.core_clk(core_clk), .rst_b(rst_b),
		.sclk(u_adcsr_link_if.sclk), .frame_sync_n(u_adcsr_link_if.frame_sync_n),
		.convert_start_n(u_adcsr_link_if.convert_start_n), .sdo(u_adcsr_link_if.sdo),
		.sdo_oe(u_adcsr_link_if.sdo_oe), .conv_done(conv_done),
		.end_of_sampling(end_of_sampling), .cfg_readback(cfg_readback));

	always @(posedge core_clk) begin
		if (end_of_sampling === 1'b1) eos_n++;
	end

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		rd_q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic start(input int cnt, input logic [15:0] bits);
		bus(1'b1, REG_CMD, {10'h0, 6'(cnt), bits});
	endtask

	// Polls busy, then fetches the received bits.
	task automatic finish();
		int k;
		k = 0;
		repeat (4) @(posedge core_clk);
		do begin
			bus(1'b0, REG_STATUS, 32'h0);
			k++;
		end while (rd_q[STAT_BUSY_BIT] !== 1'b0 && k < 300);
		if (rd_q[STAT_BUSY_BIT] !== 1'b0) n_fail++;
		bus(1'b0, REG_RXDATA, 32'h0);
	endtask

	// The trailing wait keeps the next select fall clear of the conversion end.
	task automatic conv(input logic [15:0] v, input logic c);
		@(posedge core_clk);
		conv_result <= v;
		conv_channel <= c;
		conv_done <= 1'b1;
		@(posedge core_clk);
		conv_done <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask

	function automatic logic [31:0] expect_rx(input logic [15:0] v, input logic t, input int cnt);
		logic [31:0] w;
		w = {v, t, 15'h0};
		return w >> (32 - cnt);
	endfunction

	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		close_out();
	end

	initial begin
		void'($urandom(32'hFE5A));
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CHK(cfg_readback, CFG_RESET)
		start(16, 16'h0);
		finish();
		`CHK(rd_q, 32'h0000FFFF)
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			r = (i < 3) ? corner[i] : 16'($urandom);
			ch = 1'($urandom);
			n = (i < 3) ? 16 : 11 + 2 * i;
			conv(r, ch);
			start(n, 16'h0);
			finish();
			`CHK(rd_q, expect_rx(r, ch, n))
		end
		start(4, 16'h0);
		finish();
		`CHK(rd_q, {28'h0, r[15:12]})
		$display("test results done");
		start(16, 16'h0);
		repeat (20) @(posedge core_clk);
		conv(r ^ 16'h1234, 1'b0);
		finish();
		`CHK(rd_q[15:0], r)
		start(16, 16'h0);
		finish();
		`CHK(rd_q[15:0], r ^ 16'h1234)
		$display("test select order done");
		conv(r, 1'b1);
		bus(1'b1, REG_CMD, 32'h0100_0005);
		finish();
		`CHK(rd_q, expect_rx(r, 1'b1, MIN_TAG_CLKS))
		start(16, 16'hEDFD);
		finish();
		repeat (10) @(posedge core_clk);
		`CHK(cfg_readback, 12'hDFD)
		k0 = eos_n;
		conv(16'hA5C3, 1'b1);
		`CHK(eos_n > k0, 1'b1)
		start(17, 16'h0);
		finish();
		`CHK(rd_q, expect_rx(16'hA5C3, 1'b0, 17))
		$display("test config done");
		start(16, 16'hEFFE);
		finish();
		repeat (10) @(posedge core_clk);
		`CHK(cfg_readback, CFG_RESET)
		start(16, 16'h0);
		finish();
		`CHK(rd_q, 32'h0000FFFF)
		k0 = eos_n;
		bus(1'b1, REG_CONV, 32'h0);
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK(rd_q[STAT_CONV_BIT], 1'b0)
		repeat (10) @(posedge core_clk);
		bus(1'b1, REG_CONV, 32'h1);
		`CHK(eos_n > k0, 1'b1)
		$display("test soft reset done");
		close_out();
	end
endmodule
